/* File: inc/rtag_pkg.sv */
package rtag_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_STARTUP_KEY   = 8'h00;
    localparam logic [7:0] OFS_ACCESS_UNLOCK = 8'h04;
    localparam logic [7:0] OFS_FREQ_TRIM     = 8'h08;
    localparam logic [7:0] OFS_TIME_LOAD     = 8'h0C;
    localparam logic [7:0] OFS_CAL_LOAD      = 8'h10;
    localparam logic [7:0] OFS_HOUR_FMT      = 8'h14;
    localparam logic [7:0] OFS_WEEKDAY       = 8'h18;
    localparam logic [7:0] OFS_TIME_ALARM    = 8'h1C;
    localparam logic [7:0] OFS_CAL_ALARM     = 8'h20;
    localparam logic [7:0] OFS_LEAP_YEAR     = 8'h24;
    localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h28;
    localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h2C;
    localparam logic [7:0] OFS_TICK_PERIOD   = 8'h30;
    localparam int         NUM_REGS          = 13;
    // Reset values.
    localparam logic [31:0] RST_FREQ_TRIM = 32'h0000_0700;
    localparam logic [31:0] RST_CAL_LOAD  = 32'h0005_0101;
    localparam logic [31:0] RST_HOUR_FMT  = 32'h0000_0001;
    localparam logic [31:0] RST_WEEKDAY   = 32'h0000_0006;
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    // Keys and field positions.
    localparam logic [31:0] STARTUP_KEY   = 32'hA5EB_1357;
    localparam logic [15:0] UNLOCK_PWD    = 16'hA965;
    localparam int          ACTIVE_BIT    = 0;
    localparam int          ENABLED_BIT   = 16;
    // Timing.
    localparam int          OPEN_RTC_CLKS = 1024;
    localparam int          WRITE_DELAY   = 2;
    // Access classes.
    typedef enum logic [1:0] {ACC_NONE, ACC_RO, ACC_RW} rtag_acc_type;
endpackage

/* File: rtl/rtag_sync.sv */
`timescale 1ns/1ns
// Three-stage pin synchroniser with edge report; a rising edge counts while stage two is high and stage three still low.
module rtag_sync
(
    input  wire logic SYS_CLK_I,
    input  wire logic RST_N_I,
    input  wire logic async_i,
    output logic      rise_o
);
    logic [2:0] sync_q;

    // Stage one is read only by stage two to keep metastability contained.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            sync_q <= 3'h0;
        else
            sync_q <= {sync_q[1:0], async_i};
    end

    assign rise_o = sync_q[1] & ~sync_q[2];
endmodule

/* File: rtl/rtag_top.sv */
`timescale 1ns/1ns
// Behaviour
// - The unit holds in reset until the exact start-up key is written, then stays active for good.
// - The start-up key field is write-only and reads return zero.
// - Bit 0 of the start-up register reads 0 while held in reset and 1 once active.
// - Writing the password sets the access-enabled flag, which clears itself after 1024 RTC clocks.
// - With the flag set all registers read and write except the leap-year register, read-only.
// - With the flag clear scale and interrupt registers stay read/write, time, calendar, weekday and leap-year are read-only, and trim, alarm and tick are inaccessible.
// - The low 16-bit password field is write-only and is the only way to request access.
// - Thirteen word registers are decoded at offsets 0x00 to 0x30 with per-register access.
// - Trim, calendar, hour format and weekday reset to their own values, the rest to zero.
// - The leap-year register is read-only and writes leave it unchanged.
// - A write lands in its register two RTC clocks after the bus write.
module rtag_top
#(
    parameter int OPEN_CLKS = rtag_pkg::OPEN_RTC_CLKS
)
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        RTC_CLK_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    input  wire logic        LEAP_YEAR_I,
    output logic      [31:0] RDATA_O,
    output logic             ACTIVE_O,
    output logic             ACCESS_ENABLED_FLAG_O,
    output logic             WR_PENDING_O
);
    logic [31:0] regs_q [rtag_pkg::NUM_REGS];
    logic        active_q;
    logic        enabled_q;
    logic [10:0] open_cnt_q;
    logic        pend_q;
    logic [3:0]  pend_idx_q;
    logic [31:0] pend_data_q;
    logic [1:0]  pend_cnt_q;
    logic        rtc_tick;
    logic [3:0]  idx;
    logic        in_map;
    rtag_pkg::rtag_acc_type acc;

    // Access class per register index as a function of the access flag.
    function automatic rtag_pkg::rtag_acc_type acc_of(input logic [3:0] i, input logic en);
        case (i)
            4'h0, 4'h1:       acc_of = rtag_pkg::ACC_RW;
            4'h9:             acc_of = rtag_pkg::ACC_RO;
            4'h5, 4'hA, 4'hB: acc_of = rtag_pkg::ACC_RW;
            4'h3, 4'h4, 4'h6: acc_of = en ? rtag_pkg::ACC_RW : rtag_pkg::ACC_RO;
            4'h2, 4'h7, 4'h8, 4'hC:
                acc_of = en ? rtag_pkg::ACC_RW : rtag_pkg::ACC_NONE;
            default:          acc_of = rtag_pkg::ACC_NONE;
        endcase
    endfunction

    // Reset value by register index.
    function automatic logic [31:0] rst_of(input int i);
        case (i)
            2:       rst_of = rtag_pkg::RST_FREQ_TRIM;
            4:       rst_of = rtag_pkg::RST_CAL_LOAD;
            5:       rst_of = rtag_pkg::RST_HOUR_FMT;
            6:       rst_of = rtag_pkg::RST_WEEKDAY;
            default: rst_of = rtag_pkg::RST_ZERO;
        endcase
    endfunction

    // The slow clock is a pin, so it is synchronised and used as a tick enable.
    rtag_sync u_sync
    (
        .SYS_CLK_I (SYS_CLK_I),
        .RST_N_I   (RST_N_I),
        .async_i   (RTC_CLK_I),
        .rise_o    (rtc_tick)
    );

    // Address decode: aligned words 0x00 to 0x30 only.
    assign idx    = ADDR_I[5:2];
    assign in_map = (ADDR_I[1:0] == 2'h0) && (ADDR_I[7:6] == 2'h0)
                    && (idx < 4'(rtag_pkg::NUM_REGS));
    assign acc    = in_map ? acc_of(idx, enabled_q) : rtag_pkg::ACC_NONE;

    // Start-up: only the exact key moves the unit out of reset, and nothing returns it.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            active_q <= 1'b0;
        else if (WR_I && in_map && idx == 4'(rtag_pkg::OFS_STARTUP_KEY >> 2)
                 && WDATA_I == rtag_pkg::STARTUP_KEY)
            active_q <= 1'b1;
    end

    // Access window: the password opens it, RTC ticks close it.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            enabled_q  <= 1'b0;
            open_cnt_q <= 11'h000;
        end
        else if (WR_I && in_map && idx == 4'(rtag_pkg::OFS_ACCESS_UNLOCK >> 2)
                 && WDATA_I[15:0] == rtag_pkg::UNLOCK_PWD)
        begin
            enabled_q  <= 1'b1;
            open_cnt_q <= 11'(OPEN_CLKS);
        end
        else if (rtc_tick && enabled_q)
        begin
            open_cnt_q <= open_cnt_q - 11'h001;
            if (open_cnt_q == 11'h001)
                enabled_q <= 1'b0;
        end
    end

    // Writes are held and land after two RTC ticks, matching the slow domain's latency.
    // A second write while one is pending replaces it; software should wait WR_PENDING_O.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pend_q      <= 1'b0;
            pend_idx_q  <= 4'h0;
            pend_data_q <= 32'h0000_0000;
            pend_cnt_q  <= 2'h0;
        end
        else if (WR_I && acc == rtag_pkg::ACC_RW && idx > 4'h1)
        begin
            pend_q      <= 1'b1;
            pend_idx_q  <= idx;
            pend_data_q <= WDATA_I;
            pend_cnt_q  <= 2'(rtag_pkg::WRITE_DELAY);
        end
        else if (pend_q && rtc_tick)
        begin
            pend_cnt_q <= pend_cnt_q - 2'h1;
            if (pend_cnt_q == 2'h1)
                pend_q <= 1'b0;
        end
    end

    // Register array; each storage word is its own generated flop group.
    for (genvar g = 0; g < rtag_pkg::NUM_REGS; g++)
    begin : g_reg
        always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
        begin
            if (!RST_N_I)
                regs_q[g] <= rst_of(g);
            else if (g == 9)
                regs_q[g] <= {31'h0000_0000, LEAP_YEAR_I};
            else if (g > 1 && pend_q && rtc_tick && pend_cnt_q == 2'h1
                     && pend_idx_q == 4'(g))
                regs_q[g] <= pend_data_q;
        end
    end

    // Read data stand in the cycle after the strobe; unmapped or blocked reads give zero.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            RDATA_O <= 32'h0000_0000;
        else if (RD_I && acc != rtag_pkg::ACC_NONE)
        begin
            case (idx)
                4'h0:    RDATA_O <= {31'h0000_0000, active_q};
                4'h1:    RDATA_O <= {15'h0000, enabled_q, 16'h0000};
                default: RDATA_O <= regs_q[idx];
            endcase
        end
        else
            RDATA_O <= 32'h0000_0000;
    end

    // Status outputs mirror the flops one cycle later.
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ACTIVE_O              <= 1'b0;
            ACCESS_ENABLED_FLAG_O <= 1'b0;
            WR_PENDING_O          <= 1'b0;
        end
        else
        begin
            ACTIVE_O              <= active_q;
            ACCESS_ENABLED_FLAG_O <= enabled_q;
            WR_PENDING_O          <= pend_q;
        end
    end

    a_key_sticky: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        active_q |=> active_q) else $error("active state dropped");
    a_bad_key: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!active_q && !(WR_I && in_map && idx == 4'h0 && WDATA_I == rtag_pkg::STARTUP_KEY))
        |=> !active_q) else $error("left reset without key");
    a_key_reads: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == 8'h00) |=> RDATA_O == {31'h0, $past(active_q)})
        else $error("start-up read wrong");
    a_pwd_opens: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && ADDR_I == 8'h04 && WDATA_I[15:0] == rtag_pkg::UNLOCK_PWD)
        |=> enabled_q && open_cnt_q == 11'(OPEN_CLKS)) else $error("password ignored");
    a_close_tick: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (enabled_q && rtc_tick && open_cnt_q == 11'h001 && !(WR_I && ADDR_I == 8'h04))
        |=> !enabled_q) else $error("access did not close");
    a_locked_rd: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && !enabled_q && ADDR_I == 8'h08) |=> RDATA_O == 32'h0)
        else $error("trim readable while locked");
    a_ro_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && !enabled_q && ADDR_I == 8'h0C) |=> !$rose(pend_q) && pend_idx_q == $past(pend_idx_q))
        else $error("locked time write accepted");
    a_late_land: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        $fell(pend_q) |-> $past(rtc_tick) && $past(pend_cnt_q) == 2'h1)
        else $error("write landed early");

    // The key field must never echo what software wrote; only bit 0 may be set.
    a_key_hidden: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == 8'h00) |=> RDATA_O[31:1] == 31'h0000_0000)
        else $error("start-up key field visible");

    // The password half of the access register reads as zero in every state.
    a_pwd_hidden: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && ADDR_I == 8'h04) |=> RDATA_O[15:0] == 16'h0000)
        else $error("password field visible");

    // A near-miss password must not open a closed window.
    a_bad_pwd: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!enabled_q && WR_I && ADDR_I == 8'h04 && WDATA_I[15:0] != rtag_pkg::UNLOCK_PWD)
        |=> !enabled_q) else $error("wrong password opened access");

    // Without a slow tick the open window cannot shrink or close.
    a_window_holds: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (enabled_q && !rtc_tick) |=> enabled_q)
        else $error("window closed without tick");

    // An open window accepts a time write and queues it for the slow domain.
    a_open_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && enabled_q && ADDR_I == 8'h0C) |=> pend_q && pend_idx_q == 4'h3)
        else $error("open time write dropped");

    // The time-alarm word is out of reach while the window is closed.
    a_locked_alarm: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && !enabled_q && ADDR_I == 8'h1C) |=> !$rose(pend_q))
        else $error("locked alarm write accepted");

    // The leap-year word can never become the target of a queued write.
    a_leap_queue: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        pend_q |-> pend_idx_q != 4'h9)
        else $error("leap-year write queued");

    // The leap-year word follows its input and nothing else.
    a_leap_follow: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RST_N_I |=> regs_q[9] == {31'h0000_0000, $past(LEAP_YEAR_I)})
        else $error("leap-year word altered");

    // A queued write always has ticks left to wait; zero would wrap the count to three.
    a_pend_count: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        pend_q |-> pend_cnt_q != 2'h0)
        else $error("pending write without count");

    // Read data stand only in a cycle that follows a strobe cycle and are zero otherwise.
    a_rd_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !RD_I |=> RDATA_O == 32'h0000_0000)
        else $error("read data without strobe");

    // Addresses outside the map or off word alignment read as zero.
    a_unmapped_rd: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (RD_I && !in_map) |=> RDATA_O == 32'h0000_0000)
        else $error("unmapped read returned data");

    // Status pins trail the internal state by exactly one cycle.
    a_active_pin: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RST_N_I |=> ACTIVE_O == $past(active_q))
        else $error("active pin out of step");

    // The flag pin must track the window so software polling sees the close.
    a_flag_pin: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RST_N_I |=> ACCESS_ENABLED_FLAG_O == $past(enabled_q))
        else $error("flag pin out of step");
endmodule

/* File: tb/tb_rtag_top.sv */
`timescale 1ns/1ns
// Compares a design value with its expectation; case equality keeps unknowns from matching.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module tb_rtag_top;
    logic        SYS_CLK_I   = 1'b0;
    logic        RST_N_I     = 1'b0;
    logic        RTC_CLK_I   = 1'b0;
    logic [7:0]  ADDR_I      = 8'h00;
    logic [31:0] WDATA_I     = 32'h0000_0000;
    logic        WR_I        = 1'b0;
    logic        RD_I        = 1'b0;
    logic        LEAP_YEAR_I = 1'b0;
    logic [31:0] RDATA_O;
    logic        ACTIVE_O;
    logic        ACCESS_ENABLED_FLAG_O;
    logic        WR_PENDING_O;
    int          err_count   = 0;
    int          n_tests     = 0;
    int          rtc_cnt     = 0;
    logic [7:0]  ofs;
    // A short open window keeps the expiry test brief.
    rtag_top #(.OPEN_CLKS(8)) rtag_top_inst (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
        .RTC_CLK_I(RTC_CLK_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .LEAP_YEAR_I(LEAP_YEAR_I), .RDATA_O(RDATA_O), .ACTIVE_O(ACTIVE_O),
        .ACCESS_ENABLED_FLAG_O(ACCESS_ENABLED_FLAG_O), .WR_PENDING_O(WR_PENDING_O));
    // System clock, 20 ns period.
    initial forever #10 SYS_CLK_I = ~SYS_CLK_I;
    // Slow clock pin sped up to 20 system cycles so the run stays short.
    always @(posedge SYS_CLK_I)
    begin
        rtc_cnt <= (rtc_cnt == 9) ? 0 : rtc_cnt + 1;
        if (rtc_cnt == 9) RTC_CLK_I <= ~RTC_CLK_I;
    end
    // Bus write, one strobe cycle.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK_I);
        ADDR_I <= a; WDATA_I <= d; WR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        WR_I <= 1'b0;
    endtask
    // Bus read; data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge SYS_CLK_I);
        ADDR_I <= a; RD_I <= 1'b1;
        @(posedge SYS_CLK_I);
        RD_I <= 1'b0;
        #1 `CHK(RDATA_O, e)
    endtask
    // Waits, bounded, until a delayed write has landed.
    task automatic wait_wr;
        int i;
        repeat (2) @(posedge SYS_CLK_I);
        for (i = 0; i < 200 && WR_PENDING_O !== 1'b0; i++) begin @(posedge SYS_CLK_I); #1; end
        `CHK(WR_PENDING_O, 1'b0)
    endtask
    // Locked-side expectation: trim, alarms and tick read as zero.
    function automatic logic [31:0] lk(input logic [7:0] a, input logic [31:0] v);
        return (a inside {8'h08, 8'h1C, 8'h20, 8'h30}) ? 32'h0000_0000 : v;
    endfunction
    task automatic finish_test;
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // The whole run needs under 1000 cycles; this cuts a hang well beyond that.
    initial
    begin
        #200000;
        err_count++;
        finish_test();
    end
    initial
    begin
        repeat (2) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        // Reset values as seen while locked, with the inaccessible ones reading zero.
        for (int k = 0; k < 13; k++)
        begin
            ofs = 8'(k * 4);
            rd(ofs, lk(ofs, (ofs == 8'h08) ? 32'h0000_0700 : (ofs == 8'h10) ? 32'h0005_0101 :
                (ofs == 8'h14) ? 32'h0000_0001 : (ofs == 8'h18) ? 32'h0000_0006 : 32'h0));
        end
        `CHK(ACTIVE_O, 1'b0)
        $display("test reset values done");
        // Start-up key: wrong value ignored, exact value activates for good.
        wr(8'h00, 32'hA5EB_1356);
        rd(8'h00, 32'h0000_0000);
        wr(8'h00, 32'hA5EB_1357);
        rd(8'h00, 32'h0000_0001);
        wr(8'h00, 32'h0000_0000);
        rd(8'h00, 32'h0000_0001);
        `CHK(ACTIVE_O, 1'b1)
        $display("test start-up key done");
        // Password: a near miss leaves access closed, the exact one opens it.
        wr(8'h04, 32'h0000_A964);
        rd(8'h04, 32'h0000_0000);
        LEAP_YEAR_I <= 1'b1;
        for (int k = 2; k < 13; k++)
        begin
            ofs = 8'(k * 4);
            wr(8'h04, 32'h0000_A965);
            rd(8'h04, 32'h0001_0000);
            wr(ofs, 32'h0000_0A00 | 32'(ofs));
            wait_wr();
            rd(ofs, (ofs == 8'h24) ? 32'h0000_0001 : 32'h0000_0A00 | 32'(ofs));
        end
        $display("test open access done");
        // Window runs out after the tick count, then the locked view applies.
        repeat (300) @(posedge SYS_CLK_I);
        #1 `CHK(ACCESS_ENABLED_FLAG_O, 1'b0)
        for (int k = 2; k < 13; k++)
        begin
            ofs = 8'(k * 4);
            rd(ofs, lk(ofs, (ofs == 8'h24) ? 32'h1 : 32'h0000_0A00 | 32'(ofs)));
        end
        wr(8'h0C, 32'h0000_0055);
        wait_wr();
        rd(8'h0C, 32'h0000_0A0C);
        wr(8'h08, 32'h0000_0055);
        wait_wr();
        wr(8'h28, 32'h0000_0003);
        rd(8'h28, 32'h0000_0A28);
        `CHK(WR_PENDING_O, 1'b1)
        wait_wr();
        rd(8'h28, 32'h0000_0003);
        wr(8'h04, 32'h0000_A965);
        rd(8'h08, 32'h0000_0A08);
        rd(8'h34, 32'h0000_0000);
        rd(8'h02, 32'h0000_0000);
        $display("test locked access done");
        finish_test();
    end
endmodule
